// *** src/sram_fifo_block.sv ***
// Variable-aspect 4608-bit memory block with built-in queue controller.
// Assumes user logic on clk_i drives both ports; test port is synchronous.
//
// Design decisions made here: the address map and the Wishbone slave port.
`default_nettype none
module sram_fifo_block (
   // Clock, reset and enable
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Write port
   input wire logic wr_en_i,
   input wire logic [11:0] wr_addr_i,
   input wire logic [35:0] wr_data_i,
   // Read port
   input wire logic rd_en_i,
   input wire logic [11:0] rd_addr_i,
   output logic [35:0] rd_data_o,
   // Test port preload, one 36-bit word per load
   input wire logic tp_load_i,
   input wire logic [6:0] tp_addr_i,
   input wire logic [35:0] tp_data_i,
   // Queue flags and interrupt
   output logic full_o,
   output logic empty_o,
   output logic near_full_flag_o,
   output logic near_empty_flag_o,
   output logic irq_o
);
   localparam int CW = sram_fifo_pkg::CNT_W;
   localparam int BW = sram_fifo_pkg::BIT_W;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------

   // Port width in bits for a width code
   function automatic logic [5:0] width_of(input logic [2:0] code);
      case (code)
         sram_fifo_pkg::WC_X1: width_of = 6'h01;
         sram_fifo_pkg::WC_X2: width_of = 6'h02;
         sram_fifo_pkg::WC_X4: width_of = 6'h04;
         sram_fifo_pkg::WC_X9: width_of = 6'h09;
         sram_fifo_pkg::WC_X18: width_of = 6'h12;
         default: width_of = 6'h24;
      endcase
   endfunction : width_of

   // Word count for a width code
   function automatic logic [CW-1:0] depth_of(input logic [2:0] code);
      case (code)
         sram_fifo_pkg::WC_X1: depth_of = 13'h1000;
         sram_fifo_pkg::WC_X2: depth_of = 13'h0800;
         sram_fifo_pkg::WC_X4: depth_of = 13'h0400;
         sram_fifo_pkg::WC_X9: depth_of = 13'h0200;
         sram_fifo_pkg::WC_X18: depth_of = 13'h0100;
         default: depth_of = 13'h0080;
      endcase
   endfunction : depth_of

   // First bit of a word: address folded into range, times width
   function automatic logic [BW-1:0] base_of(input logic [11:0] addr,
                                             input logic [2:0] code);
      logic [CW-1:0] a;
      logic [BW+5:0] prod;
      a = {1'b0, addr} & (depth_of(code) - 13'h0001);
      prod = a * width_of(code);
      base_of = prod[BW-1:0];
   endfunction : base_of

   // Byte-lane merge for register writes
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0] sel);
      for (int b = 0; b < 4; b++) begin
         merge[b*8 +: 8] = sel[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
      end
   endfunction : merge

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [7:0] ctrl;
      logic [CW-1:0] depth;
      logic [CW-1:0] nfull_th;
      logic [CW-1:0] nempty_th;
      logic [CW-1:0] wptr;
      logic [CW-1:0] rptr;
      logic [CW-1:0] count;
      logic full;
      logic empty;
      logic nfull;
      logic nempty;
      logic [sram_fifo_pkg::IRQ_BITS-1:0] istat;
      logic [sram_fifo_pkg::IRQ_BITS-1:0] imask;
      logic irq;
      logic ack;
      logic [31:0] dat;
      logic [35:0] rdata;
   } state_type;

   state_type cur;
   state_type next_cur;
   logic mem [0:sram_fifo_pkg::MEM_BITS-1];
   logic mem_we;
   logic [BW-1:0] mem_wbase;
   logic [5:0] mem_wwid;

   // ---------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------

   // Bus, queue control, flags and memory port steering
   always_comb begin
      logic queue;
      logic lock;
      logic [2:0] wcode;
      logic [2:0] rcode;
      logic [5:0] rwid;
      logic [CW-1:0] dmax;
      logic [CW-1:0] deff;
      logic [BW-1:0] rbase;
      logic [BW-1:0] idx;
      logic bus_req;
      logic bus_wr;
      logic push;
      logic pop;
      logic [CW-1:0] cnt;
      logic [sram_fifo_pkg::IRQ_BITS-1:0] ev;
      logic [sram_fifo_pkg::IRQ_BITS-1:0] w1c;
      logic [31:0] rd;
      logic [31:0] wv;
      logic flush;
      next_cur = cur;
      idx = '0;
      queue = cur.ctrl[sram_fifo_pkg::CTRL_QUEUE_BIT];
      lock = cur.ctrl[sram_fifo_pkg::CTRL_LOCK_BIT];
      wcode = cur.ctrl[sram_fifo_pkg::CTRL_WWID_LSB +: 3];
      rcode = queue ? wcode : cur.ctrl[sram_fifo_pkg::CTRL_RWID_LSB +: 3];
      rwid = width_of(rcode);
      dmax = depth_of(wcode);
      // Queue depth: programmed value clipped to the organisation
      deff = (cur.depth == '0 || cur.depth > dmax) ? dmax : cur.depth;
      bus_req = wb_cyc_i && wb_stb_i && !cur.ack;
      bus_wr = bus_req && wb_we_i;
      w1c = '0;
      flush = 1'b0;
      rd = 32'h00000000;
      wv = 32'h00000000;
      next_cur.ack = bus_req;
      // Register reads; unmapped offsets read zero
      case (wb_adr_i)
         sram_fifo_pkg::OFS_CTRL: rd = {24'h000000, cur.ctrl};
         sram_fifo_pkg::OFS_DEPTH: rd = {19'h00000, cur.depth};
         sram_fifo_pkg::OFS_NFULL_TH: rd = {19'h00000, cur.nfull_th};
         sram_fifo_pkg::OFS_NEMPTY_TH: rd = {19'h00000, cur.nempty_th};
         sram_fifo_pkg::OFS_STATUS: begin
            rd[sram_fifo_pkg::STAT_COUNT_LSB +: CW] = cur.count;
            rd[3:0] = {cur.nfull, cur.nempty, cur.full, cur.empty};
         end
         sram_fifo_pkg::OFS_IRQ_STAT: rd = {28'h0000000, cur.istat};
         sram_fifo_pkg::OFS_IRQ_MASK: rd = {28'h0000000, cur.imask};
         default: rd = 32'h00000000;
      endcase
      if (bus_req && !wb_we_i) begin
         next_cur.dat = rd;
      end
      // Register writes, byte lanes honoured
      if (bus_wr) begin
         wv = merge(rd, wb_dat_i, wb_sel_i);
         case (wb_adr_i)
            sram_fifo_pkg::OFS_CTRL: begin
               next_cur.ctrl = wv[7:0];
               flush = 1'b1;
            end
            sram_fifo_pkg::OFS_DEPTH: begin
               next_cur.depth = wv[CW-1:0];
               flush = 1'b1;
            end
            sram_fifo_pkg::OFS_NFULL_TH: next_cur.nfull_th = wv[CW-1:0];
            sram_fifo_pkg::OFS_NEMPTY_TH: next_cur.nempty_th = wv[CW-1:0];
            sram_fifo_pkg::OFS_IRQ_STAT: w1c = wb_dat_i[3:0] & {4{wb_sel_i[0]}};
            sram_fifo_pkg::OFS_IRQ_MASK: next_cur.imask = wv[3:0];
            default: ;
         endcase
      end
      // Queue accesses; refused ones leave pointers alone
      push = queue && wr_en_i && !cur.full;
      pop = queue && rd_en_i && !cur.empty;
      ev = '0;
      ev[sram_fifo_pkg::IRQ_OVERFLOW] = queue && wr_en_i && cur.full;
      ev[sram_fifo_pkg::IRQ_UNDERFLOW] = queue && rd_en_i && cur.empty;
      cnt = cur.count;
      if (push) begin
         next_cur.wptr = (cur.wptr == deff - 13'h0001) ? '0 : cur.wptr + 13'h0001;
      end
      if (pop) begin
         next_cur.rptr = (cur.rptr == deff - 13'h0001) ? '0 : cur.rptr + 13'h0001;
      end
      if (push && !pop) begin
         cnt = cur.count + 13'h0001;
      end else if (pop && !push) begin
         cnt = cur.count - 13'h0001;
      end
      if (flush) begin
         next_cur.wptr = '0;
         next_cur.rptr = '0;
         cnt = '0;
      end
      next_cur.count = cnt;
      // Flags registered from the next count, one clock only
      next_cur.empty = (cnt == '0);
      next_cur.full = (cnt >= deff);
      next_cur.nfull = (cnt >= next_cur.nfull_th);
      next_cur.nempty = (cnt <= next_cur.nempty_th);
      ev[sram_fifo_pkg::IRQ_NFULL] = next_cur.nfull && !cur.nfull;
      ev[sram_fifo_pkg::IRQ_NEMPTY] = next_cur.nempty && !cur.nempty;
      // Sticky status: a new event beats a same-cycle clear
      next_cur.istat = (cur.istat & ~w1c) | ev;
      next_cur.irq = |(next_cur.istat & next_cur.imask);
      // Memory write steering
      mem_wwid = width_of(wcode);
      mem_wbase = queue ? base_of(cur.wptr[11:0], wcode) : base_of(wr_addr_i, wcode);
      mem_we = queue ? push : (wr_en_i && !lock);
      // Read word assembled bit by bit at the read port width
      rbase = queue ? base_of(cur.rptr[11:0], rcode) : base_of(rd_addr_i, rcode);
      if (queue ? pop : rd_en_i) begin
         for (int i = 0; i < sram_fifo_pkg::DATA_W; i++) begin
            idx = rbase + BW'(i);
            next_cur.rdata[i] = (i < int'(rwid)) && (int'(idx) < sram_fifo_pkg::MEM_BITS)
               ? mem[idx] : 1'b0;
         end
      end
      if (rst_i) begin
         next_cur = '0;
         next_cur.ctrl = sram_fifo_pkg::CTRL_RESET;
         next_cur.depth = sram_fifo_pkg::DEPTH_RESET;
         next_cur.nfull_th = sram_fifo_pkg::NFULL_TH_RESET;
         next_cur.nempty_th = sram_fifo_pkg::NEMPTY_TH_RESET;
         next_cur.empty = 1'b1;
         next_cur.nempty = 1'b1;
         mem_we = 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------

   // State register, frozen while the enable is low, except that reset still loads it
   always_ff @(posedge clk_i) begin
      if (ce_i || rst_i) begin
         cur <= next_cur;
      end
   end

   // Storage array: test-port preload wins over a user write
   always_ff @(posedge clk_i) begin
      if (ce_i) begin
         if (tp_load_i && !rst_i) begin
            for (int i = 0; i < sram_fifo_pkg::DATA_W; i++) begin
               mem[int'(tp_addr_i) * sram_fifo_pkg::DATA_W + i] <= tp_data_i[i];
            end
         end else if (mem_we) begin
            for (int i = 0; i < sram_fifo_pkg::DATA_W; i++) begin
               if (i < int'(mem_wwid)) begin
                  mem[mem_wbase + BW'(i)] <= wr_data_i[i];
               end
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Outputs, all straight from the state register
   // ---------------------------------------------------------------
   assign wb_dat_o = cur.dat;
   assign wb_ack_o = cur.ack;
   assign rd_data_o = cur.rdata;
   assign full_o = cur.full;
   assign empty_o = cur.empty;
   assign near_full_flag_o = cur.nfull;
   assign near_empty_flag_o = cur.nempty;
   assign irq_o = cur.irq;
endmodule : sram_fifo_block
`default_nettype wire

// *** src/sram_fifo_pkg.sv ***
// Constants for the variable-aspect memory block with its queue controller.
// Assumes a 32-bit classic Wishbone register bus and one 100 MHz clock.
`default_nettype none
package sram_fifo_pkg;
   // ---------------------------------------------------------------
   // Memory geometry
   // ---------------------------------------------------------------
   localparam int MEM_BITS = 4608;
   localparam int DATA_W = 36;
   localparam int ADDR_W = 12;
   localparam int BIT_W = 13;
   localparam int CNT_W = 13;
   // Width codes: x1, x2, x4, x9, x18, x36
   localparam logic [2:0] WC_X1 = 3'h0;
   localparam logic [2:0] WC_X2 = 3'h1;
   localparam logic [2:0] WC_X4 = 3'h2;
   localparam logic [2:0] WC_X9 = 3'h3;
   localparam logic [2:0] WC_X18 = 3'h4;
   localparam logic [2:0] WC_X36 = 3'h5;
   // ---------------------------------------------------------------
   // Register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_DEPTH = 8'h04;
   localparam logic [7:0] OFS_NFULL_TH = 8'h08;
   localparam logic [7:0] OFS_NEMPTY_TH = 8'h0C;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int CTRL_QUEUE_BIT = 0;
   localparam int CTRL_WWID_LSB = 1;
   localparam int CTRL_RWID_LSB = 4;
   localparam int CTRL_LOCK_BIT = 7;
   localparam int STAT_COUNT_LSB = 16;
   localparam int IRQ_BITS = 4;
   localparam int IRQ_OVERFLOW = 0;
   localparam int IRQ_UNDERFLOW = 1;
   localparam int IRQ_NFULL = 2;
   localparam int IRQ_NEMPTY = 3;
   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] CTRL_RESET = 8'h0B;
   localparam logic [CNT_W-1:0] DEPTH_RESET = 13'h0000;
   localparam logic [CNT_W-1:0] NFULL_TH_RESET = 13'h0078;
   localparam logic [CNT_W-1:0] NEMPTY_TH_RESET = 13'h0008;
endpackage : sram_fifo_pkg
`default_nettype wire

// *** tb/fabric_user_model.sv ***
// Fabric user logic model driving the block's write and read ports.
// Assumes the bench calls its tasks from the clk_i domain.
`default_nettype none
module fabric_user_model (
   // Clock
   input wire logic clk_i,
   // Read data from the block
   input wire logic [35:0] rd_data_i,
   // Port strobes, addresses, data
   output logic wr_en_o,
   output logic [11:0] wr_addr_o,
   output logic [35:0] wr_data_o,
   output logic rd_en_o,
   output logic [11:0] rd_addr_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle port values
   initial begin
      wr_en_o = 1'b0;
      wr_addr_o = 12'h000;
      wr_data_o = 36'h0;
      rd_en_o = 1'b0;
      rd_addr_o = 12'h000;
   end
   // Push one word, then leave inverted data on the idle bus
   task automatic put(input logic [35:0] d);
      @(posedge clk_i);
      wr_en_o <= 1'b1;
      wr_data_o <= d;
      @(posedge clk_i);
      wr_en_o <= 1'b0;
      wr_data_o <= ~d;
      #1;
   endtask : put
   // Read one word, taken one edge after the strobe
   task automatic get(input logic [11:0] a, output logic [35:0] q);
      @(posedge clk_i);
      rd_en_o <= 1'b1;
      rd_addr_o <= a;
      @(posedge clk_i);
      rd_en_o <= 1'b0;
      rd_addr_o <= ~a;
      #1;
      q = rd_data_i;
   endtask : get
   // Write one word at a RAM-mode address
   task automatic poke(input logic [11:0] a, input logic [35:0] d);
      @(posedge clk_i);
      wr_en_o <= 1'b1;
      wr_addr_o <= a;
      wr_data_o <= d;
      @(posedge clk_i);
      wr_en_o <= 1'b0;
      wr_addr_o <= ~a;
      wr_data_o <= ~d;
      #1;
   endtask : poke
endmodule : fabric_user_model
`default_nettype wire

// *** tb/sram_fifo_checker.sv ***
// Checker: bus answer, flag and hold properties of the memory block.
// Assumes it is bound to sram_fifo_block and sees only its ports.
`default_nettype none
module sram_fifo_checker (
   // Clock, reset and enable
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_ack_o,
   // Ports and flags
   input wire logic wr_en_i,
   input wire logic rd_en_i,
   input wire logic [35:0] rd_data_o,
   input wire logic full_o,
   input wire logic empty_o,
   input wire logic near_empty_flag_o,
   input wire logic irq_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Queue mode as last written to the control register
   logic queue_mode;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         queue_mode <= sram_fifo_pkg::CTRL_RESET[sram_fifo_pkg::CTRL_QUEUE_BIT];
      end else if (ce_i && wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0]
         && wb_adr_i == sram_fifo_pkg::OFS_CTRL) begin
         queue_mode <= wb_dat_i[sram_fifo_pkg::CTRL_QUEUE_BIT];
      end
   end
   // -----------------------------------------
   // Bus request and its one-cycle answer
   // -----------------------------------------
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
   endsequence
   sequence s_ans;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   AST_ACK_ONE: assert property (s_req |=> s_ans)
      else $error("bus answer late or long");
   // -----------------------------------------
   // Flags and hold behaviour
   // -----------------------------------------
   AST_FULL_EMPTY: assert property (!(full_o && empty_o))
      else $error("full and empty together");
   AST_NEAR_EMPTY: assert property (empty_o |-> near_empty_flag_o)
      else $error("empty without near empty");
   AST_POP_EMPTY: assert property (empty_o && rd_en_i && !wr_en_i && !wb_cyc_i |=> empty_o)
      else $error("pop while empty changed state");
   AST_PUSH_FULL: assert property (full_o && wr_en_i && !rd_en_i && !wb_cyc_i |=> full_o)
      else $error("push while full changed state");
   AST_PUSH_FILLS: assert property (queue_mode && empty_o && wr_en_i && !rd_en_i && ce_i
      && !wb_cyc_i |=> !empty_o)
      else $error("push left queue empty");
   AST_FREEZE: assert property (!ce_i |=> $stable(rd_data_o) && $stable(empty_o))
      else $error("state moved with enable low");
   AST_RD_HOLD: assert property (!rd_en_i |=> $stable(rd_data_o))
      else $error("read data moved without read");
   AST_RST: assert property (disable iff (1'b0)
      rst_i |=> empty_o && !full_o && !wb_ack_o && !irq_o)
      else $error("reset state wrong");
endmodule : sram_fifo_checker
bind sram_fifo_block sram_fifo_checker chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_ack_o(wb_ack_o), .wr_en_i(wr_en_i),
   .rd_en_i(rd_en_i), .rd_data_o(rd_data_o), .full_o(full_o), .empty_o(empty_o),
   .near_empty_flag_o(near_empty_flag_o), .irq_o(irq_o));
`default_nettype wire

// *** tb/tb_top.sv ***
// Bench for the memory block: bus, queue, interrupt and ROM tests.
// Assumes the fabric model and the bound checker are compiled first.
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // -----------------------------------------
   // Signals
   // -----------------------------------------
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic ce_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [31:0] wb_dat_i = 32'h0;
   logic [3:0] wb_sel_i = 4'h0;
   logic tp_load_i = 1'b0;
   logic [6:0] tp_addr_i = 7'h00;
   logic [35:0] tp_data_i = 36'h0;
   logic [31:0] wb_dat_o;
   logic [11:0] wr_addr_i, rd_addr_i;
   logic [35:0] wr_data_i, rd_data_o;
   logic wb_ack_o, wr_en_i, rd_en_i, full_o, empty_o, near_full_flag_o;
   logic near_empty_flag_o, irq_o;
   int checks = 0;
   int mismatches = 0;
   // Clock, 10 ns period
   always #5 clk_i = ~clk_i;
   // Block and fabric model
   sram_fifo_block uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
      .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wr_en_i(wr_en_i),
      .wr_addr_i(wr_addr_i), .wr_data_i(wr_data_i), .rd_en_i(rd_en_i), .rd_addr_i(rd_addr_i),
      .rd_data_o(rd_data_o), .tp_load_i(tp_load_i), .tp_addr_i(tp_addr_i),
      .tp_data_i(tp_data_i), .full_o(full_o), .empty_o(empty_o),
      .near_full_flag_o(near_full_flag_o), .near_empty_flag_o(near_empty_flag_o),
      .irq_o(irq_o));
   fabric_user_model user (.clk_i(clk_i), .rd_data_i(rd_data_o), .wr_en_o(wr_en_i),
      .wr_addr_o(wr_addr_i), .wr_data_o(wr_data_i), .rd_en_o(rd_en_i), .rd_addr_o(rd_addr_i));
   // -----------------------------------------
   // Tasks
   // -----------------------------------------
   task automatic chk(input logic [35:0] got, input logic [35:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= 4'hF;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask : wb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask : wr
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, q);
      chk({4'h0, q}, {4'h0, e});
   endtask : rc
   task automatic flg(input logic [3:0] e);
      chk({32'h0, near_full_flag_o, near_empty_flag_o, full_o, empty_o}, {32'h0, e});
   endtask : flg
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : wrap_up
   // -----------------------------------------
   // Tests
   // -----------------------------------------
   initial begin
      logic [35:0] q;
      logic [71:0] m;
      int w [6];
      w = '{1, 2, 4, 9, 18, 36};
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      rc(8'h00, 32'h0000000B);
      rc(8'h08, 32'h00000078);
      rc(8'h0C, 32'h00000008);
      rc(8'h10, 32'h00000005);
      rc(8'h1C, 32'h00000000);
      $display("test reset done");
      wr(8'h08, 32'h3);
      wr(8'h0C, 32'h1);
      wr(8'h04, 32'h4);
      wr(8'h18, 32'h3);
      for (int i = 1; i <= 4; i++) begin
         user.put(36'h900000000 + 36'(i));
         flg({i >= 3, i <= 1, i == 4, 1'b0});
      end
      user.put(36'h0FFFFFFFF);
      flg(4'b1010);
      rc(8'h10, 32'h0004000A);
      chk({35'h0, irq_o}, 36'h1);
      for (int i = 1; i <= 4; i++) begin
         user.get(12'h000, q);
         chk(q, 36'h900000000 + 36'(i));
      end
      flg(4'b0101);
      user.get(12'h000, q);
      chk(q, 36'h900000004);
      rc(8'h14, 32'h0000000F);
      wr(8'h14, 32'h3);
      rc(8'h14, 32'h0000000C);
      chk({35'h0, irq_o}, 36'h0);
      $display("test queue done");
      // Push with the enable low must not land
      @(posedge clk_i);
      ce_i <= 1'b0;
      user.put(36'h1);
      flg(4'b0101);
      @(posedge clk_i);
      ce_i <= 1'b1;
      $display("test hold done");
      // Preload words 0, 1 and 127, then read at every width
      m = {36'h61234ABCD, 36'hC3A5F0E71};
      for (int k = 0; k < 3; k++) begin
         @(posedge clk_i);
         tp_load_i <= 1'b1;
         tp_addr_i <= (k == 2) ? 7'h7F : 7'(k);
         tp_data_i <= (k == 2) ? 36'h800000001 : m[36*(k%2) +: 36];
      end
      @(posedge clk_i);
      tp_load_i <= 1'b0;
      for (int c = 0; c < 6; c++) begin
         wr(8'h00, 32'(c * 16 + 10));
         user.get(12'h001, q);
         chk(q, 36'((m >> w[c]) & ((72'h1 << w[c]) - 72'h1)));
      end
      wr(8'h00, 32'h3A);
      user.get(12'h1FF, q);
      chk(q, 36'h000000100);
      $display("test rom done");
      // Locked RAM ignores user writes; unlocked it takes them
      wr(8'h00, 32'hBA);
      user.poke(12'h07F, 36'h0);
      user.get(12'h1FF, q);
      chk(q, 36'h000000100);
      wr(8'h00, 32'h3A);
      user.poke(12'h07F, 36'h0);
      user.get(12'h1FF, q);
      chk(q, 36'h0);
      $display("test lock done");
      // Mid-run reset brings back the power-up state
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      chk(rd_data_o, 36'h0);
      flg(4'b0101);
      rc(8'h00, 32'h0000000B);
      $display("test second reset done");
      wrap_up();
   end
   // Watchdog cuts a hang short
   initial begin
      #100000;
      mismatches++;
      wrap_up();
   end
endmodule : tb_top
`default_nettype wire
